// file: inc/cio_pkg.sv
/*
  Shared constants of the configurable I/O port block: pin counts, drive
  mode encodings, register indices, control bit positions and pin indices.
  Assumes the including module sees a flat pin vector, port n at n*8.
*/
package cio_pkg;
   localparam int NPORT = 3;
   localparam int NBIT  = 8;
   localparam int NPIN  = NPORT * NBIT;

   // Two mode bits per pin, {mode_bit_high, mode_bit_low}
   localparam logic [1:0] MODE_QUASI = 2'h0;
   localparam logic [1:0] MODE_PUSH  = 2'h1;
   localparam logic [1:0] MODE_INPUT = 2'h2;
   localparam logic [1:0] MODE_OD    = 2'h3;

   // Register indices; byte address is index * 4
   localparam logic [3:0] IDX_PORT0  = 4'h0;
   localparam logic [3:0] IDX_PORT1  = 4'h1;
   localparam logic [3:0] IDX_PORT2  = 4'h2;
   localparam logic [3:0] IDX_MHI0   = 4'h3;
   localparam logic [3:0] IDX_MLO0   = 4'h4;
   localparam logic [3:0] IDX_MHI1   = 4'h5;
   localparam logic [3:0] IDX_MLO1   = 4'h6;
   localparam logic [3:0] IDX_P2A    = 4'h7;
   localparam logic [3:0] IDX_MLO2   = 4'h8;

   // Spare bits of port2_mode_reg_a
   localparam int BIT_P0_SCHMITT = 5;
   localparam int BIT_CLKOUT     = 4;
   localparam int BIT_T1_TOGGLE  = 3;
   localparam int BIT_T0_TOGGLE  = 2;
   localparam int P2_MODE_PINS   = 2;

   // Fixed-function pins, flat index
   localparam int PIN_OD_A  = 10;
   localparam int PIN_OD_B  = 11;
   localparam int PIN_RST   = 13;
   localparam int PIN_XTL_A = 16;
   localparam int PIN_XTL_B = 17;

   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [1:0] STRONG_PULSE_CYC = 2'h2;
endpackage

// file: hw/cio_configurable_io_port.sv
/*
  Configurable I/O port: three 8-bit ports with per-pin drive mode,
  pull-up sequencing, fixed pins and input threshold selection, with an
  AHB-Lite register slave. Assumes pad cells outside that turn the pull
  and pull-down enables into pin drive, and static option inputs coming
  from the nonvolatile configuration logic on the same clock.
*/
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
module cio_configurable_io_port
   import cio_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic            arst_n,
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic [31:0]     hwdata,
   input  wire logic            hready,
   output logic      [31:0]     hrdata,
   output logic                 hreadyout,
   output logic                 hresp,
   input  wire logic            reset_level_high_sel,
   input  wire logic            xtalOscSel,
   input  wire logic            intResetSel,
   input  wire logic [NPIN-1:0] padIn,
   output logic      [NPIN-1:0] padPullVeryWeak,
   output logic      [NPIN-1:0] padPullWeak,
   output logic      [NPIN-1:0] padPullStrong,
   output logic      [NPIN-1:0] padPullDown,
   output logic      [NPIN-1:0] padSchmittSel,
   output logic      [NPIN-1:0] padInputEn,
   output logic                 timer0ToggleEn,
   output logic                 timer1ToggleEn,
   output logic                 clkOutEn
);

   function automatic logic [1:0] effMode(input int i, input logic [1:0] raw);
      if (i == PIN_OD_A || i == PIN_OD_B) begin
         effMode = MODE_OD;
      end else if (i == PIN_RST) begin
         effMode = MODE_INPUT;
      end else begin
         effMode = raw;
      end
   endfunction

   logic [NPIN-1:0] padMeta_reg;
   logic [NPIN-1:0] pinSync_reg;
   logic [NPIN-1:0] latch_reg;
   logic [NPIN-1:0] latch_next;
   logic [7:0]      modeHigh_reg [NPORT];
   logic [7:0]      modeHigh_next [NPORT];
   logic [7:0]      modeLow_reg [NPORT];
   logic [7:0]      modeLow_next [NPORT];
   logic [1:0]      pulse_reg [NPIN];
   logic [1:0]      pulse_next [NPIN];
   logic            initDone_reg;
   logic            wrPend_reg;
   logic            wrPend_next;
   logic [3:0]      wrIdx_reg;
   logic [3:0]      wrIdx_next;
   logic [31:0]     hrdata_reg;
   logic [31:0]     hrdata_next;
   logic [NPIN-1:0] vwNext;
   logic [NPIN-1:0] wkNext;
   logic [NPIN-1:0] stNext;
   logic [NPIN-1:0] dnNext;
   logic [NPIN-1:0] stNext_q;
   logic [NPIN-1:0] smNext;
   logic [NPIN-1:0] inEnNext;
   logic            accept;
   logic            addrOk;
   logic [7:0]      rdByte;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;
   assign accept    = hsel && hready && htrans[1];
   assign addrOk    = (haddr[1:0] == 2'h0) && (haddr[31:6] == 26'h0) && (haddr[5:2] <= IDX_MLO2);

   // Register file and bus slave
   always_comb begin
      latch_next    = latch_reg;
      modeHigh_next = modeHigh_reg;
      modeLow_next  = modeLow_reg;
      if (!initDone_reg) begin
         // Latches take the reset level at the first edge after release
         latch_next = {NPIN{reset_level_high_sel}};
      end else if (wrPend_reg) begin
         case (wrIdx_reg)
            IDX_PORT0: latch_next[7:0]   = hwdata[7:0];
            IDX_PORT1: latch_next[15:8]  = hwdata[7:0];
            IDX_PORT2: latch_next[23:16] = hwdata[7:0];
            IDX_MHI0:  modeHigh_next[0]  = hwdata[7:0];
            IDX_MLO0:  modeLow_next[0]   = hwdata[7:0];
            IDX_MHI1:  modeHigh_next[1]  = hwdata[7:0];
            IDX_MLO1:  modeLow_next[1]   = hwdata[7:0];
            IDX_P2A:   modeHigh_next[2]  = hwdata[7:0];
            IDX_MLO2:  modeLow_next[2]   = hwdata[7:0];
            default: begin
            end
         endcase
      end
      wrPend_next = accept && hwrite && addrOk;
      wrIdx_next  = haddr[5:2];
      // Read mux looks at next values so a read right after a write sees it
      case (haddr[5:2])
         IDX_PORT0: rdByte = pinSync_reg[7:0] & inEnNext[7:0];
         IDX_PORT1: rdByte = pinSync_reg[15:8] & inEnNext[15:8];
         IDX_PORT2: rdByte = pinSync_reg[23:16] & inEnNext[23:16];
         IDX_MHI0:  rdByte = modeHigh_next[0];
         IDX_MLO0:  rdByte = modeLow_next[0];
         IDX_MHI1:  rdByte = modeHigh_next[1];
         IDX_MLO1:  rdByte = modeLow_next[1];
         IDX_P2A:   rdByte = modeHigh_next[2];
         IDX_MLO2:  rdByte = modeLow_next[2];
         default:   rdByte = 8'h00;
      endcase
      hrdata_next = (accept && !hwrite && addrOk) ? {24'h0, rdByte} : 32'h0;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         latch_reg    <= '0;
         modeHigh_reg <= '{default: RST_MODE};
         modeLow_reg  <= '{default: RST_MODE};
         initDone_reg <= 1'b0;
         wrPend_reg   <= 1'b0;
         wrIdx_reg    <= 4'h0;
         hrdata_reg   <= 32'h0;
      end else begin
         latch_reg    <= latch_next;
         modeHigh_reg <= modeHigh_next;
         modeLow_reg  <= modeLow_next;
         initDone_reg <= 1'b1;
         wrPend_reg   <= wrPend_next;
         wrIdx_reg    <= wrIdx_next;
         hrdata_reg   <= hrdata_next;
      end
   end

   // Pin drive control
   always_comb begin
      logic [1:0] m;
      logic       mh;
      logic       avail;
      int         p;
      int         b;
      m     = MODE_QUASI;
      mh    = 1'b0;
      avail = 1'b0;
      p     = 0;
      b     = 0;
      for (int i = 0; i < NPIN; i++) begin
         p  = i / NBIT;
         b  = i % NBIT;
         // Upper bits of port2_mode_reg_a are other enables, not modes
         mh = (p == 2 && b >= P2_MODE_PINS) ? 1'b0 : modeHigh_reg[p][b];
         m  = effMode(i, {mh, modeLow_reg[p][b]});
         avail = !(xtalOscSel && (i == PIN_XTL_A || i == PIN_XTL_B))
                 && !(i == PIN_RST && !intResetSel);
         vwNext[i] = avail && m == MODE_QUASI && latch_reg[i];
         wkNext[i] = vwNext[i] && pinSync_reg[i];
         // Pulse is cut if the latch falls again, so the strong pull-up never fights the pull-down
         stNext_q[i] = (m == MODE_QUASI) && latch_reg[i] && (pulse_reg[i] != 2'h0);
         stNext[i] = avail && (stNext_q[i] || (m == MODE_PUSH && latch_reg[i]));
         // Open drain and input only fall out of the mode tests above
         dnNext[i] = avail && m != MODE_INPUT && !latch_reg[i];
         inEnNext[i] = avail;
         if (i == PIN_OD_A || i == PIN_OD_B || i == PIN_RST) begin
            smNext[i] = 1'b1;
         end else begin
            smNext[i] = modeHigh_reg[2][BIT_P0_SCHMITT + p];
         end
         // No pulse for the reset load, so high-reset pins source only weak current
         if (initDone_reg && latch_next[i] && !latch_reg[i]) begin
            pulse_next[i] = STRONG_PULSE_CYC;
         end else if (pulse_reg[i] != 2'h0) begin
            pulse_next[i] = pulse_reg[i] - 2'h1;
         end else begin
            pulse_next[i] = 2'h0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         padMeta_reg     <= '0;
         pinSync_reg     <= '0;
         pulse_reg       <= '{default: 2'h0};
         padPullVeryWeak <= '0;
         padPullWeak     <= '0;
         padPullStrong   <= '0;
         padPullDown     <= '0;
         padSchmittSel   <= '0;
         padInputEn      <= '0;
         timer0ToggleEn  <= 1'b0;
         timer1ToggleEn  <= 1'b0;
         clkOutEn        <= 1'b0;
      end else begin
         padMeta_reg     <= padIn;
         pinSync_reg     <= padMeta_reg;
         pulse_reg       <= pulse_next;
         padPullVeryWeak <= vwNext;
         padPullWeak     <= wkNext;
         padPullStrong   <= stNext;
         padPullDown     <= dnNext;
         padSchmittSel   <= smNext;
         padInputEn      <= inEnNext;
         timer0ToggleEn  <= modeHigh_reg[2][BIT_T0_TOGGLE];
         timer1ToggleEn  <= modeHigh_reg[2][BIT_T1_TOGGLE];
         clkOutEn        <= modeHigh_reg[2][BIT_CLKOUT];
      end
   end

   // Checks on free pins 0 to 2 (quasi, push-pull, input only) and on the fixed pins other than PIN_OD_A
   logic q0;
   logic pp1;
   logic io2;
   assign q0  = !modeHigh_reg[0][0] && !modeLow_reg[0][0];
   assign pp1 = !modeHigh_reg[0][1] && modeLow_reg[0][1];
   assign io2 = modeHigh_reg[0][2] && !modeLow_reg[0][2];

   sequence rise0_s;
      initDone_reg && latch_reg[0] && !$past(latch_reg[0]) && $past(initDone_reg) && q0;
   endsequence
   sequence hold0_s;
      (q0 && latch_reg[0]) [*3];
   endsequence

   strong_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      rise0_s ##1 hold0_s |-> !padPullStrong[0] && $past(padPullStrong[0], 1) && $past(padPullStrong[0], 2))
      else $error("strong pull-up pulse not two cycles");
   very_weak_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      q0 && latch_reg[0] |=> padPullVeryWeak[0])
      else $error("very weak pull-up missing");
   weak_pull_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      padPullWeak[0] == $past(q0 && latch_reg[0] && pinSync_reg[0]) && (!padPullWeak[0] || padPullVeryWeak[0]))
      else $error("weak pull-up does not follow latch and pin level");
   push_pull_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      pp1 |=> padPullStrong[1] == $past(latch_reg[1]) && padPullDown[1] == !$past(latch_reg[1]))
      else $error("push-pull drive wrong");
   fixed_od_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      initDone_reg |=> !(padPullVeryWeak[PIN_OD_B] || padPullWeak[PIN_OD_B] || padPullStrong[PIN_OD_B])
                       && padPullDown[PIN_OD_B] == !$past(latch_reg[PIN_OD_B]))
      else $error("fixed open-drain pin drove a pull-up");
   rst_pin_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      initDone_reg |=> padInputEn[PIN_RST] == $past(intResetSel) && !padPullDown[PIN_RST])
      else $error("reset pin availability wrong");
   xtal_pins_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      xtalOscSel |=> padInputEn[PIN_XTL_A] == 1'b0 && padPullDown[PIN_XTL_B] == 1'b0)
      else $error("crystal pins still enabled");
   reset_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(initDone_reg) |-> latch_reg == {NPIN{$past(reset_level_high_sel)}} && modeLow_reg[1] == RST_MODE)
      else $error("reset level load wrong");
   schmitt_port_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      initDone_reg |=> padSchmittSel[7:0] == {NBIT{$past(modeHigh_reg[2][BIT_P0_SCHMITT])}}
                       && padSchmittSel[PIN_RST])
      else $error("Schmitt selection wrong");
   input_only_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      io2 |=> !(padPullVeryWeak[2] || padPullWeak[2] || padPullStrong[2] || padPullDown[2]))
      else $error("input-only pin driven");
endmodule

// file: sim/cio_pad_model.sv
/*
  Pad model: the external side of the port pins, turning pull enables
  and external loads into pin levels.
  Assumes enables from the port block and a bench that drives extLow.
*/
`timescale 1ns/10ps
module cio_pad_model
   import cio_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic [NPIN-1:0] pullUp,
   input  wire logic [NPIN-1:0] pullDown,
   input  wire logic [NPIN-1:0] extLow,
   output logic      [NPIN-1:0] padLevel
);
   logic [NPIN-1:0] drift = '0;

   // A floating pin has no defined level, so it wanders every cycle
   always @(posedge clk_sys) begin
      drift <= ~drift;
   end

   // An external sink overpowers the pull-ups
   assign padLevel = ~pullDown & ~extLow & (pullUp | drift);
endmodule

// file: sim/cio_configurable_io_port_bench.sv
/*
  Self-checking bench of the configurable I/O port: AHB-Lite tasks, a
  reference of the pad controls and the scenario sequence.
  Assumes a zero-wait slave and the pad model on the pins.
*/
`timescale 1ns/10ps
module cio_configurable_io_port_bench
   import cio_pkg::*;
;
   logic            clk_sys              = 1'b0;
   logic            arst_n               = 1'b0;
   logic            hsel                 = 1'b0;
   logic [31:0]     haddr                = 32'h0;
   logic [1:0]      htrans               = 2'h0;
   logic            hwrite               = 1'b0;
   logic [31:0]     hwdata               = 32'h0;
   logic            reset_level_high_sel = 1'b1;
   logic            xtalOscSel           = 1'b0;
   logic            intResetSel          = 1'b1;
   logic [NPIN-1:0] extLow               = '0;
   logic [NPIN-1:0] lat, mh, ml, padIn, padPullVeryWeak, padPullWeak;
   logic [NPIN-1:0] padPullStrong, padPullDown, padSchmittSel, padInputEn;
   logic [7:0]      p2a;
   logic [31:0]     hrdata;
   logic            hready, hreadyout, hresp, timer0ToggleEn, timer1ToggleEn, clkOutEn;
   int              fail_count           = 0;
   int              checks               = 0;

   assign hready = hreadyout;
   always #2.5 clk_sys = ~clk_sys;

   cio_configurable_io_port cio_configurable_io_port_i (
      .clk_sys, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .reset_level_high_sel, .xtalOscSel, .intResetSel, .padIn,
      .padPullVeryWeak, .padPullWeak, .padPullStrong, .padPullDown, .padSchmittSel,
      .padInputEn, .timer0ToggleEn, .timer1ToggleEn, .clkOutEn);

   cio_pad_model cio_pad_model_i (
      .clk_sys, .pullUp(padPullVeryWeak | padPullWeak | padPullStrong),
      .pullDown(padPullDown), .extLow, .padLevel(padIn));

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [31:0] q);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk_sys); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic setr(input logic [3:0] idx, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, {26'h0, idx, 2'h0}, d, q);
      case (idx)
         IDX_PORT0: lat[7:0] = d;
         IDX_PORT1: lat[15:8] = d;
         IDX_PORT2: lat[23:16] = d;
         IDX_MHI0: mh[7:0] = d;
         IDX_MLO0: ml[7:0] = d;
         IDX_MHI1: mh[15:8] = d;
         IDX_MLO1: ml[15:8] = d;
         IDX_P2A: p2a = d;
         IDX_MLO2: ml[23:16] = d;
         default: ;
      endcase
      mh[17:16] = p2a[1:0];
   endtask

   task automatic rdchk(input logic [3:0] idx, input logic [7:0] e);
      logic [31:0] q;
      xfer(1'b0, {26'h0, idx, 2'h0}, 8'h00, q);
      cmp("register read", {24'h0, e}, q);
   endtask

   // Steady pad controls and port reads; floating pins are left out of reads
   task automatic chk_pads;
      logic [NPIN-1:0] vw, wk, st, pd, ie, sc, lv, mk;
      logic [1:0]      m;
      logic [31:0]     q;
      // Pad controls move at the clock edge; look just after it
      #1;
      for (int i = 0; i < NPIN; i++) begin
         m = (i == PIN_OD_A || i == PIN_OD_B) ? MODE_OD : {mh[i], ml[i]};
         m = (i == PIN_RST) ? MODE_INPUT : m;
         vw[i] = (m == MODE_QUASI) && lat[i];
         wk[i] = vw[i] && !extLow[i];
         st[i] = (m == MODE_PUSH) && lat[i];
         pd[i] = (m != MODE_INPUT) && !lat[i];
         ie[i] = (i == PIN_RST) ? intResetSel : 1'b1;
         sc[i] = p2a[BIT_P0_SCHMITT + i / NBIT] || i == PIN_OD_A || i == PIN_OD_B || i == PIN_RST;
         if (xtalOscSel && (i == PIN_XTL_A || i == PIN_XTL_B)) begin
            {vw[i], wk[i], st[i], pd[i], ie[i]} = 5'h0;
         end
      end
      lv = ~pd & ~extLow & (vw | st);
      mk = pd | extLow | vw | st | ~ie;
      cmp("very weak pull", 32'(vw), 32'(padPullVeryWeak));
      cmp("weak pull", 32'(wk), 32'(padPullWeak));
      cmp("strong pull", 32'(st), 32'(padPullStrong));
      cmp("pull down", 32'(pd), 32'(padPullDown));
      cmp("input enable", 32'(ie), 32'(padInputEn));
      cmp("schmitt", 32'(sc), 32'(padSchmittSel));
      cmp("enables", 32'(p2a[4:2]), 32'({clkOutEn, timer1ToggleEn, timer0ToggleEn}));
      for (int p = 0; p < NPORT; p++) begin
         xfer(1'b0, 32'(p * 4), 8'h00, q);
         cmp("port read", {24'h0, lv[p*8 +: 8] & ie[p*8 +: 8]}, {q[31:8], q[7:0] & mk[p*8 +: 8]});
      end
   endtask

   task automatic rst(input logic hi, input logic xt, input logic ir);
      @(posedge clk_sys);
      arst_n <= 1'b0;
      reset_level_high_sel <= hi;
      xtalOscSel <= xt;
      intResetSel <= ir;
      repeat (4) @(posedge clk_sys);
      arst_n <= 1'b1;
      lat = {NPIN{hi}};
      mh = '0;
      ml = '0;
      p2a = 8'h00;
      repeat (8) @(posedge clk_sys);
   endtask

   task automatic stop_test;
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      rst(1'b1, 1'b0, 1'b1);
      chk_pads;
      for (int k = 3; k <= 8; k++) begin
         rdchk(4'(k), 8'h00);
      end
      setr(4'h9, 8'hff);
      rdchk(4'h9, 8'h00);
      cmp("response", 32'h0, {31'h0, hresp});
      extLow <= 24'h000002;
      repeat (8) @(posedge clk_sys);
      chk_pads;
      extLow <= '0;
      setr(IDX_PORT0, 8'hfe);
      repeat (8) @(posedge clk_sys);
      setr(IDX_PORT0, 8'hff);
      for (int k = 1; k <= 3; k++) begin
         @(posedge clk_sys);
         #1;
         cmp("strong pulse", (k < 3) ? 32'h1 : 32'h0, 32'(padPullStrong));
      end
      // Port 0 gets every mode twice; port 1 goes input-only around its fixed pins
      setr(IDX_MHI0, 8'hcc);
      setr(IDX_MLO0, 8'haa);
      setr(IDX_MHI1, 8'hff);
      setr(IDX_MLO1, 8'h00);
      setr(IDX_MLO2, 8'h03);
      rdchk(IDX_MHI0, 8'hcc);
      rdchk(IDX_MLO2, 8'h03);
      for (int k = 0; k < 2; k++) begin
         setr(IDX_P2A, k ? 8'h5a : 8'ha5);
         setr(IDX_PORT0, k ? 8'hf0 : 8'h0f);
         setr(IDX_PORT1, k ? 8'hf0 : 8'h0f);
         setr(IDX_PORT2, k ? 8'hf0 : 8'h0f);
         repeat (8) @(posedge clk_sys);
         chk_pads;
      end
      rst(1'b0, 1'b1, 1'b0);
      chk_pads;
      stop_test;
   end

   initial begin
      #50000;
      fail_count++;
      stop_test;
   end
endmodule
